// >>> verilog/icp_regs.svh
// Purpose: constants for the serial programming port
// Assumes: 50 MHz system clock
// Notes: field positions of the 32-bit command and response word
`ifndef ICP_REGS_SVH
`define ICP_REGS_SVH
`define ICP_WORD_W 32
`define ICP_BIT_DATA_SEL 29
`define ICP_BIT_CODE_SEL 28
`define ICP_BIT_READ 24
`define ICP_ADDR_HI 17
`define ICP_ADDR_LO 8
`define ICP_DATA_HI 7
`define ICP_DATA_LO 0
`define ICP_ADDR_W 10
`define ICP_DATA_W 8
`define ICP_BITCNT_W 6
`define ICP_BITCNT_LAST 6'h20
`define ICP_PULSES_TO_RUN 2'h2
`endif

// >>> verilog/icp_pkg.sv
// Purpose: types for the serial programming port
// Assumes: nothing beyond the constants header
// Notes: states are gray coded from IDLE through WAIT; the WAIT to SHIFT return is not
`default_nettype none
package icp_pkg;
    typedef enum logic [2:0] {
        ICP_IDLE  = 3'h0,
        ICP_SHIFT = 3'h1,
        ICP_ARM   = 3'h3,
        ICP_EXEC  = 3'h2,
        ICP_WAIT  = 3'h6
    } icp_state_type;

    // memory access request toward the device memories
    typedef struct packed {
        logic data_sel;
        logic code_sel;
        logic write;
        logic [9:0] addr;
        logic [7:0] wdata;
    } icp_req_type;
endpackage
`default_nettype wire

// >>> verilog/icp_port.sv
// Purpose: device side of the four-wire serial programming port
// Assumes: all pins asynchronous to clock; memory answers with mem_done
// Notes: pin edges are found by sampling; link clock runs far slower
`include "icp_regs.svh"
`default_nettype none
module icp_port (
    input wire logic clock,
    input wire logic rst,
    input wire logic prog_mode,
    input wire logic pin_load_line,
    input wire logic pin_serial_input,
    input wire logic pin_shift_clock,
    output logic pin_serial_output,
    output logic mem_req,
    output icp_pkg::icp_req_type mem_cmd,
    input wire logic mem_done,
    input wire logic [`ICP_DATA_W-1:0] mem_rdata,
    output logic ready_flag
);
    ////////////////////////////////////////////////////////////////////
    logic [1:0] load_s_q, sin_s_q, sck_s_q, mode_s_q;
    logic sck_prev_q;
    logic sck_rise;
    logic [`ICP_WORD_W-1:0] word_q;
    logic [`ICP_BITCNT_W-1:0] bits_q;
    logic [1:0] pulses_q;
    icp_pkg::icp_state_type state_q;

    // two flops on every pin before any logic reads it
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            load_s_q <= 2'h0;
            sin_s_q <= 2'h0;
            sck_s_q <= 2'h0;
            mode_s_q <= 2'h0;
        end else begin
            load_s_q <= {load_s_q[0], pin_load_line};
            sin_s_q <= {sin_s_q[0], pin_serial_input};
            sck_s_q <= {sck_s_q[0], pin_shift_clock};
            mode_s_q <= {mode_s_q[0], prog_mode};
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sck_prev_q <= 1'b0;
        end else begin
            sck_prev_q <= sck_s_q[1];
        end
    end

    assign sck_rise = sck_s_q[1] & ~sck_prev_q;

    ////////////////////////////////////////////////////////////////////
    // protocol sequencer; rst models power loss, so mode is left there
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= icp_pkg::ICP_IDLE;
            word_q <= '0;
            bits_q <= '0;
            pulses_q <= 2'h0;
            pin_serial_output <= 1'b1;
            mem_req <= 1'b0;
            mem_cmd <= '0;
            ready_flag <= 1'b0;
        end else if (!mode_s_q[1]) begin
            state_q <= icp_pkg::ICP_IDLE;
            pin_serial_output <= 1'b1;
            mem_req <= 1'b0;
        end else begin
            case (state_q)
                icp_pkg::ICP_IDLE: begin
                    // held word is zero after reset, or keeps the last word after a mode exit
                    bits_q <= '0;
                    if (load_s_q[1]) begin
                        state_q <= icp_pkg::ICP_SHIFT;
                        pin_serial_output <= word_q[`ICP_WORD_W-1];
                    end
                end
                icp_pkg::ICP_SHIFT: begin
                    if (!load_s_q[1]) begin
                        state_q <= icp_pkg::ICP_ARM;
                        pulses_q <= 2'h0;
                    end else if (sck_rise) begin
                        // msb first in, previous response out alongside
                        word_q <= {word_q[`ICP_WORD_W-2:0],
                                   sin_s_q[1]};
                        pin_serial_output <=
                            word_q[`ICP_WORD_W-2];
                        if (bits_q != `ICP_BITCNT_LAST) begin
                            bits_q <= bits_q + 6'h1;
                        end
                    end
                end
                icp_pkg::ICP_ARM: begin
                    if (sck_rise) begin
                        pin_serial_output <= 1'b0;
                        ready_flag <= 1'b0;
                        if (pulses_q + 2'h1 == `ICP_PULSES_TO_RUN) begin
                            state_q <= icp_pkg::ICP_EXEC;
                            mem_req <= 1'b1;
                            mem_cmd.data_sel <=
                                word_q[`ICP_BIT_DATA_SEL];
                            mem_cmd.code_sel <=
                                word_q[`ICP_BIT_CODE_SEL];
                            mem_cmd.write <=
                                ~word_q[`ICP_BIT_READ];
                            // same addresses as the processor uses
                            mem_cmd.addr <=
                                word_q[`ICP_ADDR_HI:`ICP_ADDR_LO];
                            mem_cmd.wdata <=
                                word_q[`ICP_DATA_HI:`ICP_DATA_LO];
                        end
                        pulses_q <= pulses_q + 2'h1;
                    end
                end
                icp_pkg::ICP_EXEC: begin
                    // extra clock pulses while busy are ignored
                    if (mem_done) begin
                        mem_req <= 1'b0;
                        state_q <= icp_pkg::ICP_WAIT;
                        if (!mem_cmd.write) begin
                            word_q[`ICP_DATA_HI:`ICP_DATA_LO] <=
                                mem_rdata;
                        end
                        // address bits stay in place as the echo
                        word_q[`ICP_ADDR_HI:`ICP_ADDR_LO] <=
                            mem_cmd.addr;
                    end
                end
                icp_pkg::ICP_WAIT: begin
                    ready_flag <= 1'b1;
                    pin_serial_output <= 1'b1;
                    if (load_s_q[1]) begin
                        state_q <= icp_pkg::ICP_SHIFT;
                        bits_q <= '0;
                        pin_serial_output <= word_q[`ICP_WORD_W-1];
                    end
                end
                default: state_q <= icp_pkg::ICP_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    busy_by_second_a: assert property (@(posedge clock)
        disable iff (rst)
        (state_q == icp_pkg::ICP_EXEC) |-> !pin_serial_output)
        else $error("serial out not low while executing");

    exec_needs_low_a: assert property (@(posedge clock)
        disable iff (rst)
        $rose(mem_req) |-> !$past(load_s_q[1]))
        else $error("execute started with load high");

    read_dir_a: assert property (@(posedge clock)
        disable iff (rst)
        $rose(mem_req) |-> mem_cmd.write == !word_q[`ICP_BIT_READ])
        else $error("direction bit decoded wrongly");

    addr_echo_a: assert property (@(posedge clock)
        disable iff (rst)
        $rose(mem_req) |->
            mem_cmd.addr == word_q[`ICP_ADDR_HI:`ICP_ADDR_LO])
        else $error("address not taken from command");

    // a short word is not refused, so the count is only watched here
    word_full_a: assert property (@(posedge clock)
        disable iff (rst)
        $rose(mem_req) |-> bits_q == `ICP_BITCNT_LAST)
        else $error("command launched before a full word");

    ready_clear_a: assert property (@(posedge clock)
        disable iff (rst)
        $rose(mem_req) |-> !ready_flag)
        else $error("ready flag still set while executing");

    done_release_a: assert property (@(posedge clock)
        disable iff (rst)
        (state_q == icp_pkg::ICP_WAIT) && !load_s_q[1] && mode_s_q[1]
            |=> pin_serial_output && ready_flag)
        else $error("handshake not released after completion");

    read_data_a: assert property (@(posedge clock)
        disable iff (rst)
        mem_req && mem_done && !mem_cmd.write && mode_s_q[1] |=>
            word_q[`ICP_DATA_HI:`ICP_DATA_LO] == $past(mem_rdata))
        else $error("read byte not captured");

    shift_msb_a: assert property (@(posedge clock)
        disable iff (rst)
        (state_q == icp_pkg::ICP_SHIFT) && load_s_q[1] && sck_rise
            && mode_s_q[1] |=> word_q[0] == $past(sin_s_q[1]))
        else $error("serial input not shifted in");

    mode_exit_a: assert property (@(posedge clock)
        disable iff (rst)
        !mode_s_q[1] |=> state_q == icp_pkg::ICP_IDLE && !mem_req)
        else $error("programming mode not left");
endmodule
`default_nettype wire

// >>> bench/icp_prog.sv
// Purpose: programmer model driving the serial port pins
// Assumes: 160 ns shift clock, four system clocks a half period
// Notes: shift clock stands low between frames
`default_nettype none
module icp_prog (
    input wire logic clock,
    input wire logic pin_serial_output,
    output logic pin_load_line,
    output logic pin_serial_input,
    output logic pin_shift_clock,
    output logic busy_low
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        pin_load_line = 1'b0;
        pin_serial_input = 1'b0;
        pin_shift_clock = 1'b0;
        busy_low = 1'b0;
    end
    task step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////
    task xfer(input logic [31:0] cmd, output logic [31:0] rsp);
        int i;
        pin_load_line = 1'b1;
        step(4);
        for (i = 31; i >= 0; i--) begin
            pin_serial_input = cmd[i];
            step(4);
            pin_shift_clock = 1'b1;
            step(1);
            // output moves some 60 ns after the rise, so read early
            rsp[i] = pin_serial_output;
            step(3);
            pin_shift_clock = 1'b0;
        end
        // idle data line shows the inverse, never the stale bit
        pin_serial_input = ~cmd[0];
        step(4);
        pin_load_line = 1'b0;
        step(4);
        for (i = 0; i < 2; i++) begin
            pin_shift_clock = 1'b1;
            step(4);
            busy_low = !pin_serial_output;
            pin_shift_clock = 1'b0;
            step(4);
        end
        i = 0;
        while (pin_serial_output !== 1'b1 && i < 1000) begin
            step(1);
            i++;
        end
    endtask
endmodule
`default_nettype wire

// >>> bench/test_icp_port.sv
// Purpose: self-checking bench for the serial programming port
// Assumes: memory answers five clocks after a request
// Notes: first response after entry is never judged
`default_nettype none
module test_icp_port;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, rst = 1, prog_mode = 0, mem_done = 0, mem_req;
    logic ready_flag, sout, load, sin, sclk, busy;
    logic [7:0] mem_rdata = 8'h00;
    logic [7:0] mem [2048];
    logic [31:0] rsp, c;
    icp_pkg::icp_req_type mem_cmd, last;
    int dly = 0, n_mismatch = 0, tests_run = 0;
    always #10 clock = ~clock;
    icp_port dut_u (.clock(clock), .rst(rst), .prog_mode(prog_mode),
        .pin_load_line(load), .pin_serial_input(sin),
        .pin_shift_clock(sclk), .pin_serial_output(sout),
        .mem_req(mem_req), .mem_cmd(mem_cmd), .mem_done(mem_done),
        .mem_rdata(mem_rdata), .ready_flag(ready_flag));
    icp_prog prog_u (.clock(clock), .pin_serial_output(sout),
        .pin_load_line(load), .pin_serial_input(sin),
        .pin_shift_clock(sclk), .busy_low(busy));
    ////////////////////////////////////////////////////////////////////
    always @(posedge clock) begin
        #1 mem_done = 1'b0;
        dly = mem_req ? dly + 1 : 0;
        if (dly == 5) begin
            last = mem_cmd;
            mem_done = 1'b1;
            mem_rdata = mem[{mem_cmd.code_sel, mem_cmd.addr}];
            if (mem_cmd.write)
                mem[{mem_cmd.code_sel, mem_cmd.addr}] = mem_cmd.wdata;
        end
    end
    task chk(input bit ok, input string m);
        tests_run++;
        if (!ok) begin
            n_mismatch++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    task conclude;
        $display("mismatches %0d checks %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    function automatic logic [31:0] mk(logic [1:0] s, logic r,
            logic [9:0] a, logic [7:0] d);
        return {2'h0, s, 3'h0, r, 6'h00, a, d};
    endfunction
    ////////////////////////////////////////////////////////////////////
    task t_idle;
        chk(sout === 1'b1 && mem_req === 1'b0, "idle pins");
        chk(ready_flag === 1'b0, "ready at reset");
        $display("test idle done");
    endtask
    task t_chain;
        logic [31:0] cmds [5];
        logic [7:0] ed [5];
        cmds = '{mk(2'h2, 0, 10'h3ff, 8'ha5), mk(2'h1, 0, 10'h001, 8'h3c),
            mk(2'h2, 1, 10'h3ff, 8'h00), mk(2'h1, 1, 10'h001, 8'h00),
            mk(2'h2, 0, 10'h000, 8'hff)};
        ed = '{8'ha5, 8'h3c, 8'ha5, 8'h3c, 8'hff};
        for (int i = 0; i < 5; i++) begin
            c = cmds[i];
            prog_u.xfer(c, rsp);
            chk(sout === 1'b1, "handshake timeout");
            chk(busy === 1'b1, "busy not low");
            chk(ready_flag === 1'b1, "ready not set");
            chk(last.data_sel === c[29], "data sel");
            chk(last.code_sel === c[28], "code sel");
            chk(last.write === !c[24], "direction");
            chk(last.addr === c[17:8], "address");
            if (!c[24])
                chk(last.wdata === c[7:0], "write data");
            if (i > 0)
                chk(rsp[17:0] === {cmds[i-1][17:8], ed[i-1]}, "resp");
        end
        $display("test chain done");
    endtask
    // programming voltage drops while a write is executing
    task t_abort;
        c = mk(2'h2, 0, 10'h020, 8'h5a);
        fork
            prog_u.xfer(c, rsp);
            begin
                @(posedge mem_req);
                prog_u.step(1);
                prog_mode = 1'b0;
            end
        join
        chk(mem_req === 1'b0 && sout === 1'b1, "mode exit");
        chk(ready_flag === 1'b0, "aborted write completed");
        chk(last.addr !== 10'h020, "aborted write reached memory");
        $display("test abort done");
    endtask
    task t_power;
        prog_u.step(1);
        rst = 1'b1;
        prog_mode = 1'b0;
        prog_u.step(3);
        chk(sout === 1'b1 && ready_flag === 1'b0, "power loss");
        $display("test power done");
    endtask
    initial begin
        #500000;
        n_mismatch++;
        $display("[ERR] %0t watchdog", $time);
        conclude;
    end
    initial begin
        repeat (5) @(posedge clock);
        #1 rst = 1'b0;
        prog_mode = 1'b1;
        prog_u.step(4);
        t_idle;
        t_chain;
        t_abort;
        t_power;
        conclude;
    end
endmodule
`default_nettype wire
